// ---- logic/spfc_top.sv ----
// What this block does
// - all pins reset to system function
// - bit 12 selects erase or port line
// - bits 10,11 select usb or port
// - bits 7..4 select debug or port
// - pad settings apply in both modes
// - scan select high enables boundary scan
// - jtag first, switch sequence enters swd
// - trace drives data-out only in swd
// - test pin selects test or programming
// - reset pin bidirectional, low resets device
// - pin reset spares backup region
// - any external pulse, driven pulse minimum
// - reset pin input after reset
// - valid erase sets flash to ones
// - debounce erase, ignore under 100 ms
// - erase after high beyond 220 ms
// - port output never triggers erase
// - erase also clears region lock bits
module spfc_top
  import spfc_pkg::*;
(
  input  wire logic        REF_CLK,
  input  wire logic        RST_B,
  input  wire logic [7:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic [31:0]      RDATA,
  output logic [12:0]      PIN_SELECT,
  output logic             TRACE_ON_DATA_OUT,
  output logic             SCAN_ENABLE,
  output logic             TEST_MODE_ENABLE,
  input  wire logic        SCAN_MODE_IS_PROG,
  output logic             FLASH_PROG_ENABLE,
  input  wire logic        BOUNDARY_SCAN_SELECT_PIN,
  input  wire logic        TEST_MODE_PIN,
  input  wire logic        DEBUG_CLK_PIN,
  input  wire logic        DEBUG_MODE_PIN,
  input  wire logic        ERASE_PIN,
  input  wire logic        BIDIR_RESET_PIN_I,
  output logic             BIDIR_RESET_PIN_O,
  output logic             BIDIR_RESET_PIN_OE,
  output logic             CORE_PERIPH_RESET_B,
  output logic             BACKUP_RESET_B,
  output logic             FLASH_ERASE_ALL,
  output logic             LOCK_CLEAR_ALL
);

  logic [12:0] sysio_r;        // pin function select word
  logic [2:0]  s1_r;           // first sync stage: scan, test, ext reset
  logic [2:0]  s2_r;           // second sync stage
  logic [1:0]  dbg1_r;         // debug clock/mode first stage
  logic [1:0]  dbg2_r;         // debug clock/mode second stage
  logic        dclk_d_r;       // previous synced debug clock
  logic        er1_r;          // erase sync first stage
  logic        er2_r;          // erase sync second stage
  logic [15:0] slow_div_r;     // slow tick divider
  logic        slow_tick_r;    // one-cycle slow enable
  logic [15:0] er_cnt_r;       // debounce count in slow ticks
  logic        er_done_r;      // erase fired for this assertion
  logic        erased_r;       // erase happened since reset
  spfc_dp_e    dp_r;           // active debug port
  logic [15:0] key_r;          // shift of debug mode bits
  logic [7:0]  rst_cnt_r;      // driven reset pulse counter
  logic        rst_seen_r;     // external reset observed

  // pin function selects, software steered
  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
      sysio_r <= SPFC_SYSIO_RST;
    else if (WR && ADDR == SPFC_SYSIO_OFS)
      sysio_r <= WDATA[12:0] & SPFC_SYSIO_MASK;
  end

  // pad settings live outside; the select only steers the function
  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
      PIN_SELECT <= SPFC_SYSIO_RST;
    else
      PIN_SELECT <= sysio_r;
  end

  // read data, valid in the cycle after the read strobe
  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      RDATA  <= 32'h0000_0000;
    end
    else
    begin
      if (!RD)
        RDATA <= 32'h0000_0000;
      else
        case (ADDR)
          SPFC_SYSIO_OFS:  RDATA <= {19'h0, sysio_r};
          SPFC_STATUS_OFS: RDATA <= {27'h0, erased_r, rst_seen_r, s2_r[1], s2_r[0],
                                     dp_r == SPFC_DP_SWD};
          SPFC_RSTCTL_OFS: RDATA <= {31'h0, BIDIR_RESET_PIN_OE};
          default:         RDATA <= 32'h0000_0000;  // unmapped reads zero
        endcase
    end
  end

  // two-stage synchronisers for pin inputs
  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      // reset pin idles high, scan and test pins idle low on their pulls
      s1_r   <= 3'h4;
      s2_r   <= 3'h4;
      dbg1_r <= 2'h0;
      dbg2_r <= 2'h0;
      er1_r  <= 1'b0;
      er2_r  <= 1'b0;
    end
    else
    begin
      s1_r   <= {BIDIR_RESET_PIN_I, TEST_MODE_PIN, BOUNDARY_SCAN_SELECT_PIN};
      s2_r   <= s1_r;
      dbg1_r <= {DEBUG_MODE_PIN, DEBUG_CLK_PIN};
      dbg2_r <= dbg1_r;
      er1_r  <= ERASE_PIN;
      er2_r  <= er1_r;
    end
  end

  // scan select and test mode decode
  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      SCAN_ENABLE       <= 1'b0;
      TEST_MODE_ENABLE  <= 1'b0;
      FLASH_PROG_ENABLE <= 1'b0;
    end
    else
    begin
      SCAN_ENABLE       <= s2_r[0] || (s2_r[1] && !SCAN_MODE_IS_PROG);
      TEST_MODE_ENABLE  <= s2_r[1];
      FLASH_PROG_ENABLE <= s2_r[1] && SCAN_MODE_IS_PROG;
    end
  end

  // debug port switch: key shifted on rising debug clock
  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      dp_r     <= SPFC_DP_JTAG;
      key_r    <= 16'h0000;
      dclk_d_r <= 1'b0;
    end
    else
    begin
      dclk_d_r <= dbg2_r[0];
      if (dbg2_r[0] && !dclk_d_r)
      begin
        key_r <= {dbg2_r[1], key_r[15:1]};
        if ({dbg2_r[1], key_r[15:1]} == SPFC_SWITCH_KEY)
          dp_r <= SPFC_DP_SWD;
      end
    end
  end

  // trace only in serial-wire mode and system function
  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
      TRACE_ON_DATA_OUT <= 1'b0;
    else
      TRACE_ON_DATA_OUT <= dp_r == SPFC_DP_SWD && !sysio_r[SPFC_DBG_OUT_BIT];
  end

  // reset pin: software command drives a minimum pulse
  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
      rst_cnt_r <= 8'h00;
    else if (WR && ADDR == SPFC_RSTCTL_OFS && WDATA[0])
      rst_cnt_r <= 8'(SPFC_RST_PULSE_CYC);
    else if (rst_cnt_r != 8'h00)
      rst_cnt_r <= rst_cnt_r - 8'h01;
  end

  // reset pin drive, open drain low
  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      BIDIR_RESET_PIN_O  <= 1'b0;
      BIDIR_RESET_PIN_OE <= 1'b0;
    end
    else
    begin
      BIDIR_RESET_PIN_O  <= 1'b0;
      BIDIR_RESET_PIN_OE <= rst_cnt_r != 8'h00;
    end
  end

  // external low resets core only, any length
  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      CORE_PERIPH_RESET_B <= 1'b0;
      BACKUP_RESET_B      <= 1'b0;
      rst_seen_r          <= 1'b0;
    end
    else
    begin
      CORE_PERIPH_RESET_B <= s2_r[2];
      BACKUP_RESET_B      <= 1'b1;
      if (!s2_r[2])
        rst_seen_r <= 1'b1;
    end
  end

  // slow clock enable divider
  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      slow_div_r  <= 16'h0000;
      slow_tick_r <= 1'b0;
    end
    else
    begin
      slow_tick_r <= slow_div_r == 16'(SPFC_SLOW_DIV - 1);
      slow_div_r  <= (slow_div_r == 16'(SPFC_SLOW_DIV - 1)) ? 16'h0000
                                                             : slow_div_r + 16'h0001;
    end
  end

  // erase debounce; port mode blocks it entirely
  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
      er_cnt_r <= 16'h0000;
    else if (!er2_r || sysio_r[SPFC_ERASE_BIT])
      er_cnt_r <= 16'h0000;
    else if (slow_tick_r && er_cnt_r != 16'hFFFF)
      er_cnt_r <= er_cnt_r + 16'h0001;
  end

  // one erase per assertion after threshold
  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      er_done_r       <= 1'b0;
      erased_r        <= 1'b0;
      FLASH_ERASE_ALL <= 1'b0;
      LOCK_CLEAR_ALL  <= 1'b0;
    end
    else
    begin
      FLASH_ERASE_ALL <= 1'b0;
      LOCK_CLEAR_ALL  <= 1'b0;
      if (er_cnt_r == 16'h0000)
        er_done_r <= 1'b0;
      else if (!er_done_r && er_cnt_r >= 16'(SPFC_ERASE_TICKS))
      begin
        er_done_r       <= 1'b1;
        erased_r        <= 1'b1;
        FLASH_ERASE_ALL <= 1'b1;
        LOCK_CLEAR_ALL  <= 1'b1;
      end
    end
  end

  erase_gate_a: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    $rose(FLASH_ERASE_ALL) |-> !$past(sysio_r[SPFC_ERASE_BIT], 2) && $past(er2_r, 2))
    else $error("erase while in port mode");
  erase_lock_a: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    FLASH_ERASE_ALL == LOCK_CLEAR_ALL)
    else $error("lock clear not paired with erase");
  erase_min_a: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    FLASH_ERASE_ALL |-> $past(er_cnt_r) >= 16'(SPFC_IGNORE_TICKS))
    else $error("erase before ignore time");
  trace_jtag_a: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    dp_r == SPFC_DP_JTAG |=> !TRACE_ON_DATA_OUT)
    else $error("trace during jtag");
  rst_pulse_a: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    $rose(BIDIR_RESET_PIN_OE) |-> BIDIR_RESET_PIN_OE[*8])
    else $error("reset pulse too short");
  backup_keep_a: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    !s2_r[2] |=> BACKUP_RESET_B && !CORE_PERIPH_RESET_B)
    else $error("pin reset hit backup region");
  scan_sel_a: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    s2_r[0] |=> SCAN_ENABLE)
    else $error("scan select ignored");
  sel_write_a: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    WR && ADDR == SPFC_SYSIO_OFS |=> ##1 PIN_SELECT[SPFC_ERASE_BIT] == $past(WDATA[12], 2))
    else $error("erase select not applied");
  // port mode holds the debounce count at zero
  port_block_a: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    sysio_r[SPFC_ERASE_BIT] |=> er_cnt_r == 16'h0000)
    else $error("erase count ran in port mode");
  // a low synced level restarts the debounce
  cnt_restart_a: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    !er2_r |=> er_cnt_r == 16'h0000)
    else $error("erase count kept after low");
endmodule // spfc_top

// ---- common/spfc_pkg.sv ----
package spfc_pkg;
  // register map, byte addresses of aligned words
  localparam logic [7:0] SPFC_SYSIO_OFS   = 8'h00;  // pin function select word
  localparam logic [7:0] SPFC_STATUS_OFS  = 8'h04;  // block state readback
  localparam logic [7:0] SPFC_RSTCTL_OFS  = 8'h08;  // reset pin drive command

  // select bit positions in the pin function word
  localparam int SPFC_DBG_IN_BIT   = 4;   // debug data in
  localparam int SPFC_DBG_OUT_BIT  = 5;   // debug data out / trace
  localparam int SPFC_DBG_MODE_BIT = 6;   // debug mode / data
  localparam int SPFC_DBG_CLK_BIT  = 7;   // debug clock
  localparam int SPFC_USB_M_BIT    = 10;  // usb minus line
  localparam int SPFC_USB_P_BIT    = 11;  // usb plus line
  localparam int SPFC_ERASE_BIT    = 12;  // erase pin
  localparam logic [12:0] SPFC_SYSIO_RST   = 13'h0000;  // all system functions
  localparam logic [12:0] SPFC_SYSIO_MASK  = 13'h1CF0;  // implemented select bits

  // status bit positions
  localparam int SPFC_ST_SWD_BIT   = 0;   // serial-wire port active
  localparam int SPFC_ST_SCAN_BIT  = 1;   // boundary scan selected
  localparam int SPFC_ST_TEST_BIT  = 2;   // test mode pin high
  localparam int SPFC_ST_RSTIN_BIT = 3;   // external reset seen
  localparam int SPFC_ST_ERASE_BIT = 4;   // erase performed

  // timing
  localparam int SPFC_CLK_HZ       = 40_000_000;
  localparam int SPFC_SLOW_HZ      = 32_000;      // slow debounce clock rate
  localparam int SPFC_SLOW_DIV     = SPFC_CLK_HZ / SPFC_SLOW_HZ;
  localparam int SPFC_IGNORE_MS    = 100;
  localparam int SPFC_ERASE_MS     = 220;
  localparam int SPFC_IGNORE_TICKS = SPFC_IGNORE_MS * SPFC_SLOW_HZ / 1000;
  localparam int SPFC_ERASE_TICKS  = SPFC_ERASE_MS * SPFC_SLOW_HZ / 1000 + 1;
  localparam int SPFC_RST_PULSE_NS = 1000;        // minimum driven reset pulse
  localparam int SPFC_RST_PULSE_CYC =
    (SPFC_RST_PULSE_NS * (SPFC_CLK_HZ / 1_000_000) + 999) / 1000;

  // debug port state
  typedef enum logic [1:0]
  {
    SPFC_DP_JTAG = 2'b00,
    SPFC_DP_SWD  = 2'b01
  } spfc_dp_e;

  // switch sequence key, sent lsb first on mode line
  localparam logic [15:0] SPFC_SWITCH_KEY = 16'hE79E;
endpackage

// ---- bench/spfc_board.sv ----
// board, reset circuit and debug probe around the pin block
module spfc_board
(
  input  wire logic clk,
  input  wire logic rst_drv_o,
  input  wire logic rst_drv_oe,
  output logic      reset_pin,
  output logic      debug_clk,
  output logic      debug_mode,
  output logic      erase_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ext_reset_b;  // push-button level, high when idle
  // pull-up wins unless a party drives low
  assign reset_pin = (rst_drv_oe ? rst_drv_o : 1'b1) & ext_reset_b;
  // erase held low at startup, debug clock still outside frames
  initial
  begin
    ext_reset_b = 1'b1;
    erase_pin = 1'b0;
    debug_clk = 1'b0;
    debug_mode = 1'b0;
  end
  // switch sequence, lsb first, one bit per debug clock
  task automatic send_key(input logic [15:0] key);
    for (int i = 0; i < 16; i++)
    begin
      @(posedge clk);
      debug_mode <= key[i];
      repeat (4) @(posedge clk);
      debug_clk <= 1'b1;
      repeat (4) @(posedge clk);
      debug_clk <= 1'b0;
    end
    @(posedge clk);
    debug_mode <= ~key[15];  // released line does not keep last bit
  endtask
  // external low pulse on the reset pin
  task automatic push_reset(input int cycles);
    @(posedge clk);
    ext_reset_b <= 1'b0;
    repeat (cycles) @(posedge clk);
    ext_reset_b <= 1'b1;
  endtask
  // erase pin high for a number of clock cycles
  task automatic hold_erase(input int cycles);
    @(posedge clk);
    erase_pin <= 1'b1;
    repeat (cycles) @(posedge clk);
    erase_pin <= 1'b0;
  endtask
endmodule // spfc_board

// ---- bench/spfc_top_tb.sv ----
// self-checking bench of the pin function block
module spfc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import spfc_pkg::*;
  logic        REF_CLK, RST_B, WR, RD, SCAN_MODE_IS_PROG, BSCAN, TPIN;
  logic [7:0]  ADDR;
  logic [31:0] WDATA, RDATA, d;
  logic [12:0] PIN_SELECT;
  logic        TRACE_ON_DATA_OUT, SCAN_ENABLE, TEST_MODE_ENABLE, FLASH_PROG_ENABLE;
  logic        rpin, rst_o, rst_oe, core_b, backup_b, erase_all, lock_clr, dclk, dmode, epin;
  int          fail_count, comparisons, erase_seen, n;
  spfc_top DUT (.REF_CLK(REF_CLK), .RST_B(RST_B), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .PIN_SELECT(PIN_SELECT), .TRACE_ON_DATA_OUT(TRACE_ON_DATA_OUT),
    .SCAN_ENABLE(SCAN_ENABLE), .TEST_MODE_ENABLE(TEST_MODE_ENABLE),
    .SCAN_MODE_IS_PROG(SCAN_MODE_IS_PROG), .FLASH_PROG_ENABLE(FLASH_PROG_ENABLE),
    .BOUNDARY_SCAN_SELECT_PIN(BSCAN), .TEST_MODE_PIN(TPIN), .DEBUG_CLK_PIN(dclk),
    .DEBUG_MODE_PIN(dmode), .ERASE_PIN(epin), .BIDIR_RESET_PIN_I(rpin),
    .BIDIR_RESET_PIN_O(rst_o), .BIDIR_RESET_PIN_OE(rst_oe), .CORE_PERIPH_RESET_B(core_b),
    .BACKUP_RESET_B(backup_b), .FLASH_ERASE_ALL(erase_all), .LOCK_CLEAR_ALL(lock_clr));
  spfc_board board (.clk(REF_CLK), .rst_drv_o(rst_o), .rst_drv_oe(rst_oe), .reset_pin(rpin),
    .debug_clk(dclk), .debug_mode(dmode), .erase_pin(epin));
  // 40 MHz clock
  initial
  begin
    REF_CLK = 1'b0;
    forever #12.5 REF_CLK = ~REF_CLK;
  end
  // erase pulses are never expected in this run
  always @(posedge REF_CLK)
    if (erase_all === 1'b1 || lock_clr === 1'b1)
      erase_seen++;
  // one compare with report
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge REF_CLK);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= v;
    @(posedge REF_CLK);
    WR <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge REF_CLK);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge REF_CLK);
    RD <= 1'b0;
    #1 v = RDATA;
  endtask
  // let synchronised pins settle
  task automatic settle();
    repeat (5) @(posedge REF_CLK);
    #1;
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // watchdog, tests need about 16k cycles
  initial
  begin
    repeat (40000) @(posedge REF_CLK);
    fail_count++;
    stop_test();
  end
  initial
  begin
    {RST_B, WR, RD, SCAN_MODE_IS_PROG, BSCAN, TPIN} = '0;
    ADDR = 8'h00;
    WDATA = 32'h0;
    repeat (3) @(posedge REF_CLK);
    RST_B <= 1'b1;
    settle();
    // reset state
    rd(SPFC_SYSIO_OFS, d);
    chk("sysio reset", 32'h0, d);
    chk("pin select reset", 32'h0, {19'h0, PIN_SELECT});
    chk("reset pin input", 32'h0, {31'h0, rst_oe});
    chk("trace in jtag", 32'h0, {31'h0, TRACE_ON_DATA_OUT});
    $display("test reset done");
    // each select bit alone, then all bits
    for (int b = 0; b < 13; b++)
    begin
      wr(SPFC_SYSIO_OFS, 32'h1 << b);
      @(posedge REF_CLK);
      #1 chk("pin select bit", (32'h1 << b) & 32'h1CF0, {19'h0, PIN_SELECT});
    end
    wr(SPFC_SYSIO_OFS, 32'hFFFFFFFF);
    rd(SPFC_SYSIO_OFS, d);
    chk("sysio all", {19'h0, SPFC_SYSIO_MASK}, d);
    chk("usb and erase select", 32'h7, {29'h0, PIN_SELECT[12:10]});
    $display("test select done");
    // scan and test pins
    @(posedge REF_CLK);
    BSCAN <= 1'b1;
    settle();
    chk("scan from select pin", 32'h1, {31'h0, SCAN_ENABLE});
    @(posedge REF_CLK);
    BSCAN <= 1'b0;
    TPIN <= 1'b1;
    settle();
    chk("test scan", 32'h3, {30'h0, TEST_MODE_ENABLE, SCAN_ENABLE});
    @(posedge REF_CLK);
    SCAN_MODE_IS_PROG <= 1'b1;
    settle();
    chk("test prog", 32'h2, {30'h0, FLASH_PROG_ENABLE, SCAN_ENABLE});
    @(posedge REF_CLK);
    TPIN <= 1'b0;
    settle();
    chk("normal run", 32'h0, {30'h0, TEST_MODE_ENABLE, FLASH_PROG_ENABLE});
    $display("test mode pins done");
    // debug port switch, wrong key first
    wr(SPFC_SYSIO_OFS, 32'h0);
    board.send_key(16'h1234);
    settle();
    rd(SPFC_STATUS_OFS, d);
    chk("swd after bad key", 32'h0, {31'h0, d[SPFC_ST_SWD_BIT]});
    board.send_key(SPFC_SWITCH_KEY);
    settle();
    rd(SPFC_STATUS_OFS, d);
    chk("swd after key", 32'h1, {31'h0, d[SPFC_ST_SWD_BIT]});
    chk("trace in swd", 32'h1, {31'h0, TRACE_ON_DATA_OUT});
    wr(SPFC_SYSIO_OFS, 32'h20);
    settle();
    chk("trace on port line", 32'h0, {31'h0, TRACE_ON_DATA_OUT});
    $display("test debug port done");
    // second reset mid-run: selects and debug port back to defaults
    @(posedge REF_CLK);
    RST_B <= 1'b0;
    repeat (3) @(posedge REF_CLK);
    RST_B <= 1'b1;
    settle();
    rd(SPFC_STATUS_OFS, d);
    chk("swd after reset", 32'h0, {31'h0, d[SPFC_ST_SWD_BIT]});
    chk("scan after reset", 32'h0, {31'h0, d[SPFC_ST_SCAN_BIT]});
    chk("pin select after reset", 32'h0, {19'h0, PIN_SELECT});
    chk("trace after reset", 32'h0, {31'h0, TRACE_ON_DATA_OUT});
    $display("test second reset done");
    // driven reset pulse length and external reset
    wr(SPFC_RSTCTL_OFS, 32'h1);
    n = 0;
    repeat (SPFC_RST_PULSE_CYC + 20)
    begin
      @(posedge REF_CLK);
      #1 if (rst_oe === 1'b1 && rst_o === 1'b0)
        n++;
    end
    chk("driven pulse cycles", SPFC_RST_PULSE_CYC, n);
    settle();
    // pulse runs beside the wait so the low level is seen while it lasts
    fork
      board.push_reset(10);
    join_none
    settle();
    chk("core reset low", 32'h0, {31'h0, core_b});
    chk("backup kept", 32'h1, {31'h0, backup_b});
    repeat (20) @(posedge REF_CLK);
    #1 chk("core reset released", 32'h1, {31'h0, core_b});
    $display("test reset pin done");
    // short erase ignored, port line never erases
    wr(SPFC_SYSIO_OFS, 32'h0);
    board.hold_erase(SPFC_SLOW_DIV * 4);
    settle();
    wr(SPFC_SYSIO_OFS, 32'h1000);
    board.hold_erase(SPFC_SLOW_DIV * 8);
    settle();
    chk("no erase pulse", 32'h0, erase_seen);
    chk("no erase from port", 32'h0, erase_seen);
    $display("test erase pin done");
    stop_test();
  end
endmodule // spfc_top_tb
